// file: common/sff_pkg.sv
// shared constants, types and helpers for the serial frame-format port
package sff_pkg;

    // register byte offsets
    localparam logic [7:0] SFF_TX_DATA_OFS = 8'h00;
    localparam logic [7:0] SFF_RX_DATA_OFS = 8'h04;
    localparam logic [7:0] SFF_STATUS_OFS = 8'h08;
    localparam logic [7:0] SFF_PORT_CTRL_OFS = 8'h18;
    localparam logic [7:0] SFF_FRAME_FORMAT_OFS = 8'h1c;
    localparam logic [7:0] SFF_BAUD_DIVISOR_OFS = 8'h20;
    localparam logic [7:0] SFF_RECEIVE_COUNT_OFS = 8'h24;
    localparam logic [7:0] SFF_SELECT_OUTPUT_OFS = 8'h28;
    localparam logic [7:0] SFF_WORD_LENGTH_OFS = 8'h2c;

    // reset values
    localparam logic [6:0] SFF_FRAME_FORMAT_RST = 7'h08;
    localparam logic [15:0] SFF_BAUD_DIVISOR_RST = 16'h0002;
    localparam logic [15:0] SFF_RECEIVE_COUNT_RST = 16'h0001;
    localparam logic [7:0] SFF_SELECT_OUTPUT_RST = 8'hff;
    localparam logic [4:0] SFF_WORD_LENGTH_RST = 5'h08;
    localparam logic [11:0] SFF_PORT_CTRL_RST = 12'h004;

    // frame_format_ctrl fields
    localparam int SFF_FF_CLOCK_PHASE = 0;
    localparam int SFF_FF_IDLE_CLOCK_LEVEL = 1;
    localparam int SFF_FF_LSB_FIRST = 2;
    localparam int SFF_FF_SHORT_WORD_LENGTH = 3;
    localparam int SFF_FF_MASTER_LATE_SAMPLE = 4;
    localparam int SFF_FF_SLAVE_EARLY_DRIVE = 5;
    localparam int SFF_FF_PHASE_INVERT_SELECT = 6;

    // port_ctrl fields
    localparam int SFF_PC_PORT_ENABLE = 0;
    localparam int SFF_PC_HOST_MODE = 2;
    localparam int SFF_PC_RX_ONLY = 4;
    localparam int SFF_PC_AUDIO_MODE = 8;
    localparam int SFF_PC_AUDIO_CHANNEL_LENGTH = 9;
    localparam int SFF_PC_SELECT_CTRL = 10;
    localparam int SFF_PC_WIDE_WORD_SELECT = 11;

    // status fields
    localparam int SFF_ST_BUSY = 0;
    localparam int SFF_ST_RX_VALID = 1;

    // word lengths
    localparam logic [5:0] SFF_LEN_32 = 6'h20;
    localparam logic [5:0] SFF_LEN_16 = 6'h10;
    localparam logic [5:0] SFF_LEN_8 = 6'h08;
    localparam logic [5:0] SFF_LEN_7 = 6'h07;
    localparam logic [4:0] SFF_EXT_LEN_MAX = 5'h00;

    localparam logic [1:0] SFF_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        SFF_IDLE = 2'b00,
        SFF_RUN = 2'b01,
        SFF_TAIL = 2'b11
    } sff_state_t;

    function automatic logic [5:0] sff_word_len(
        input logic wide,
        input logic short_len,
        input logic [4:0] ext_len,
        input logic audio,
        input logic audio_channel_length
    );
        if (audio) begin
            return audio_channel_length ? SFF_LEN_32 : SFF_LEN_16;
        end else if (wide) begin
            return (ext_len == SFF_EXT_LEN_MAX) ? SFF_LEN_32
                                                : {1'b0, ext_len};
        end
        return short_len ? SFF_LEN_8 : SFF_LEN_7;
    endfunction

    function automatic logic [4:0] sff_bit_pos(
        input logic [5:0] idx,
        input logic [5:0] len,
        input logic lsb
    );
        logic [5:0] rev;
        rev = len - idx - 6'h01;
        return lsb ? idx[4:0] : rev[4:0];
    endfunction

endpackage

// file: hw/sff_baud_gen.sv
// baud generator: two clock-edge ticks per serial period of div cycles
`timescale 1ns/1ns
module sff_baud_gen #(
    parameter int DIV_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_a_o,
    output logic tick_b_o
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] half;

    // divisor is only taken while stopped, so a word never mixes rates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= DIV_W'(sff_pkg::SFF_BAUD_DIVISOR_RST);
        end else if (!run_i) begin
            div_q <= div_i;
        end
    end

    assign half = div_q >> 1;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt <= '0;
        end else if (cnt == div_q - DIV_W'(1)) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + DIV_W'(1);
        end
    end

    // first edge at half a period, second at the full period
    assign tick_a_o = run_i && (cnt == half - DIV_W'(1));
    assign tick_b_o = run_i && (cnt == div_q - DIV_W'(1));
endmodule

// file: hw/sff_shifter.sv
// word shifter for master and slave timing with configurable frame format
`timescale 1ns/1ns
module sff_shifter
    import sff_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic master_i,
    input wire logic start_i,
    input wire logic [5:0] len_i,
    input wire logic lsb_i,
    input wire logic phase_i,
    input wire logic idle_clock_level_i,
    input wire logic late_i,
    input wire logic early_i,
    input wire logic tick_a_i,
    input wire logic tick_b_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic [31:0] tx_word_i,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] rx_word_o,
    output logic sclk_o,
    output logic sdo_o
);
    sff_state_t state;
    logic [5:0] len_q;
    logic lsb_q, ph_q, late_q, early_q, idle_clock_level_q, master_q;
    logic [31:0] tx_q;
    logic [5:0] ecnt, ccnt;
    logic pend, sclk_prev, bit_q;
    logic lead, trail, sample_ev, drive_ev, capture, last_cap;
    logic slave_go, abort, tick;
    logic [5:0] ecnt_n;

    assign tick = tick_a_i || tick_b_i;
    assign lead = master_q ? tick_a_i
                : (sclk_i != sclk_prev) && (sclk_prev == idle_clock_level_q);
    assign trail = master_q ? tick_b_i
                 : (sclk_i != sclk_prev) && (sclk_prev != idle_clock_level_q);
    // effective phase 1 samples on the first edge, 0 on the second
    assign sample_ev = (state == SFF_RUN) && (ph_q ? lead : trail); // see RULE3
    assign drive_ev = (state == SFF_RUN) && (ph_q ? trail : lead);
    assign ecnt_n = sample_ev ? ecnt + 6'h01 : ecnt;
    // late sampling holds the capture to the following edge
    assign capture = master_q && late_q ? pend && tick // see RULE8
                                        : sample_ev;
    assign last_cap = capture && (ccnt == len_q - 6'h01);
    assign slave_go = enable_i && !master_i && !cs_n_i;
    assign abort = !master_q && cs_n_i;

    always_ff @(posedge clk_i) begin
        sclk_prev <= sclk_i;
    end

    // settings are caught only while idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_q <= SFF_LEN_8;
            lsb_q <= 1'b0;
            ph_q <= 1'b0;
            late_q <= 1'b0;
            early_q <= 1'b0;
            idle_clock_level_q <= 1'b0;
            master_q <= 1'b0;
            tx_q <= '0;
        end else if (state == SFF_IDLE) begin // see RULE21
            len_q <= len_i;
            lsb_q <= lsb_i;
            ph_q <= phase_i;
            late_q <= late_i;
            early_q <= early_i;
            idle_clock_level_q <= idle_clock_level_i;
            master_q <= master_i;
            tx_q <= tx_word_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SFF_IDLE;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                SFF_IDLE: begin
                    if ((start_i && master_i && enable_i) || slave_go) begin
                        state <= SFF_RUN;
                    end
                end
                SFF_RUN: begin
                    if (!enable_i || abort) begin
                        state <= SFF_IDLE;
                    end else if (!master_q && last_cap) begin
                        state <= SFF_IDLE;
                        done_o <= 1'b1;
                    end else if (master_q && tick_b_i && ecnt_n == len_q) begin
                        state <= (late_q && !ph_q) ? SFF_TAIL : SFF_IDLE;
                        done_o <= !(late_q && !ph_q);
                    end
                end
                SFF_TAIL: begin
                    if (!enable_i) begin
                        state <= SFF_IDLE;
                    end else if (tick) begin
                        state <= SFF_IDLE;
                        done_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state == SFF_IDLE) begin
            ecnt <= '0;
            ccnt <= '0;
            pend <= 1'b0;
        end else begin
            ecnt <= ecnt_n;
            if (capture) begin
                ccnt <= ccnt + 6'h01;
            end
            if (master_q && late_q) begin
                pend <= sample_ev ? 1'b1 : (tick ? 1'b0 : pend);
            end
        end
    end

    // bit order picks the index of each bit in the word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_word_o <= '0;
        end else if (state != SFF_IDLE && capture) begin
            if (ccnt == '0) begin
                rx_word_o <= '0;
            end
            rx_word_o[sff_bit_pos(ccnt, len_q, lsb_q)] <= sdi_i; // see RULE5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_q <= 1'b0;
        end else if (state == SFF_IDLE) begin
            bit_q <= tx_word_i[sff_bit_pos(6'h00, len_i, lsb_i)];
        end else if (drive_ev && ecnt < len_q) begin
            bit_q <= tx_q[sff_bit_pos(ecnt, len_q, lsb_q)]; // see RULE5
        end
    end

    // a slow slave sends each bit one core cycle after the drive edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
        end else if (master_q || early_q) begin // see RULE7
            sdo_o <= (drive_ev && ecnt < len_q)
                   ? tx_q[sff_bit_pos(ecnt, len_q, lsb_q)] : bit_q;
        end else begin
            sdo_o <= bit_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_o <= 1'b0;
        end else if (state != SFF_RUN) begin
            sclk_o <= idle_clock_level_i; // see RULE4
        end else if (master_q && tick) begin
            sclk_o <= !sclk_o;
        end
    end

    assign busy_o = (state != SFF_IDLE);
endmodule

// file: hw/sff_top.sv
// serial port frame format, baud select and select output behind AHB-Lite
//
// How it works
// RULE1 - port stays disabled until port_enable is set, runs only while set
// RULE2 - phase_invert_select set flips the programmed clock phase
// RULE3 - effective phase 0 samples on the second edge, 1 on the first
// RULE4 - serial clock idles at the idle_clock_level value
// RULE5 - lsb_first set shifts least significant bit first, else msb first
// RULE6 - narrow mode: short_word_length 0 gives 7-bit, 1 gives 8-bit words
// RULE7 - slave drives data one edge later unless slave_early_drive is set
// RULE8 - master samples mid-bit, or at the trailing edge if late sample set
// RULE9 - audio mode forces invert and short length to 1, lsb and phase to 0
// RULE10 - master serial clock is bus clock divided by the baud divisor
// RULE11 - software never writes 0 or 1 into the baud divisor
// RULE12 - master receive-only takes receive_count words per receive run
// RULE13 - software never writes zero to the receive count register
// RULE14 - software select drives active-low select from select bit 0
// RULE15 - wide mode word length is extended_length, 0 meaning 32 bits
// RULE16 - narrow mode keeps extended_length at eight
// RULE17 - audio mode ignores extended_length, uses 32 or 16 bit words
// RULE18 - wide_word_select 0 uses low 8 data bits, 1 uses all 32
// RULE19 - select control 0 uses software select, 1 hardware select
// RULE20 - host mode uses internal baud clock, slave takes external clock
// RULE21 - format, length and divisor changes take effect between words
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sff_top
    import sff_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE_O,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE_O,
    input wire logic CS_N_I,
    output logic CS_N_O
);
    import sff_pkg::*;

    logic [6:0] frame_format_ctrl;
    logic [DIV_W-1:0] baud_divisor_reg;
    logic [15:0] receive_count_reg;
    logic [7:0] select_output_reg;
    logic [4:0] word_length_reg;
    logic [11:0] port_ctrl;
    logic [31:0] tx_data;
    logic rx_valid;
    logic [15:0] rx_left;
    logic wr_pend, rd_rx;
    logic [7:0] wr_addr;
    logic addr_ok, tx_wr, start;
    logic [31:0] rd_mux;
    logic enable, master, audio, wide;
    logic eff_phase, eff_lsb, eff_short, eff_inv;
    logic [5:0] word_len;
    logic busy, done, tick_a, tick_b, sclk_int, sdo_int;
    logic [31:0] rx_word;

    assign enable = port_ctrl[SFF_PC_PORT_ENABLE]; // see RULE1
    assign master = port_ctrl[SFF_PC_HOST_MODE]; // see RULE20
    assign audio = port_ctrl[SFF_PC_AUDIO_MODE];
    // audio mode keeps the wide data path
    assign wide = port_ctrl[SFF_PC_WIDE_WORD_SELECT] || audio;

    // audio mode overrides the four format bits
    assign eff_inv = audio ? 1'b1 // see RULE9
                   : frame_format_ctrl[SFF_FF_PHASE_INVERT_SELECT];
    assign eff_short = audio ? 1'b1
                     : frame_format_ctrl[SFF_FF_SHORT_WORD_LENGTH];
    assign eff_lsb = audio ? 1'b0 : frame_format_ctrl[SFF_FF_LSB_FIRST];
    assign eff_phase = (audio ? 1'b0 : frame_format_ctrl[SFF_FF_CLOCK_PHASE])
                     ^ eff_inv; // see RULE2

    assign word_len = sff_word_len(wide, eff_short, // see RULE6
                                   word_length_reg, audio, // see RULE15
                                   port_ctrl[SFF_PC_AUDIO_CHANNEL_LENGTH]);
                                   // see RULE17

    // single-cycle slave: address phase captured, write in data phase
    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            rd_rx <= 1'b0;
        end else begin
            wr_pend <= addr_ok && HWRITE_I;
            rd_rx <= addr_ok && !HWRITE_I
                  && (HADDR_I == SFF_RX_DATA_OFS);
            if (addr_ok) begin
                wr_addr <= HADDR_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            HREADYOUT_O <= 1'b0;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (HADDR_I)
            SFF_RX_DATA_OFS:
                rd_mux = wide ? rx_word : {24'h00_0000, rx_word[7:0]};
                // see RULE18
            SFF_STATUS_OFS: begin
                rd_mux[SFF_ST_BUSY] = busy;
                rd_mux[SFF_ST_RX_VALID] = rx_valid;
            end
            SFF_PORT_CTRL_OFS: rd_mux = {20'h0_0000, port_ctrl};
            SFF_FRAME_FORMAT_OFS: rd_mux = {25'h000_0000, frame_format_ctrl};
            SFF_BAUD_DIVISOR_OFS: rd_mux = 32'(baud_divisor_reg);
            SFF_RECEIVE_COUNT_OFS: rd_mux = {16'h0000, receive_count_reg};
            SFF_SELECT_OUTPUT_OFS: rd_mux = {24'h00_0000, select_output_reg};
            SFF_WORD_LENGTH_OFS: rd_mux = {27'h000_0000, word_length_reg};
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            HRDATA_O <= '0;
        end else if (addr_ok && !HWRITE_I) begin
            HRDATA_O <= rd_mux;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            frame_format_ctrl <= SFF_FRAME_FORMAT_RST;
            baud_divisor_reg <= DIV_W'(SFF_BAUD_DIVISOR_RST); // see RULE10
            receive_count_reg <= SFF_RECEIVE_COUNT_RST;
            select_output_reg <= SFF_SELECT_OUTPUT_RST;
            word_length_reg <= SFF_WORD_LENGTH_RST;
            port_ctrl <= SFF_PORT_CTRL_RST;
            tx_data <= '0;
        end else if (wr_pend) begin
            unique case (wr_addr)
                SFF_TX_DATA_OFS:
                    tx_data <= wide ? HWDATA_I
                                    : {24'h00_0000, HWDATA_I[7:0]};
                SFF_PORT_CTRL_OFS: port_ctrl <= HWDATA_I[11:0];
                SFF_FRAME_FORMAT_OFS: frame_format_ctrl <= HWDATA_I[6:0];
                SFF_BAUD_DIVISOR_OFS:
                    baud_divisor_reg <= HWDATA_I[DIV_W-1:0];
                SFF_RECEIVE_COUNT_OFS: receive_count_reg <= HWDATA_I[15:0];
                SFF_SELECT_OUTPUT_OFS: select_output_reg <= HWDATA_I[7:0];
                SFF_WORD_LENGTH_OFS: word_length_reg <= HWDATA_I[4:0];
                default: ;
            endcase
        end
    end

    assign tx_wr = wr_pend && (wr_addr == SFF_TX_DATA_OFS);

    // receive-only master repeats words until the count is used up
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || !enable) begin
            rx_left <= '0;
        end else if (tx_wr && !busy && master) begin
            rx_left <= port_ctrl[SFF_PC_RX_ONLY]
                     ? receive_count_reg : 16'h0001; // see RULE12
        end else if (done && rx_left != 16'h0000) begin
            rx_left <= rx_left - 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            start <= 1'b0;
        end else begin
            start <= (tx_wr && !busy && master && enable)
                  || (done && master && port_ctrl[SFF_PC_RX_ONLY]
                      && rx_left > 16'h0001);
        end
    end

    // a new word sets the flag even in the cycle its read clears it
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rx_valid <= 1'b0;
        end else if (done) begin
            rx_valid <= 1'b1;
        end else if (rd_rx) begin
            rx_valid <= 1'b0;
        end
    end

    sff_baud_gen #(
        .DIV_W(DIV_W)
    ) u_baud (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .run_i(busy && master && enable), // see RULE10
        .div_i(baud_divisor_reg),
        .tick_a_o(tick_a),
        .tick_b_o(tick_b)
    );

    sff_shifter u_shift (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .enable_i(enable),
        .master_i(master),
        .start_i(start),
        .len_i(word_len),
        .lsb_i(eff_lsb),
        .phase_i(eff_phase),
        .idle_clock_level_i(frame_format_ctrl[SFF_FF_IDLE_CLOCK_LEVEL]),
        .late_i(frame_format_ctrl[SFF_FF_MASTER_LATE_SAMPLE]),
        .early_i(frame_format_ctrl[SFF_FF_SLAVE_EARLY_DRIVE]),
        .tick_a_i(tick_a),
        .tick_b_i(tick_b),
        .sclk_i(SCLK_I),
        .cs_n_i(CS_N_I),
        .sdi_i(SDI_I),
        .tx_word_i(tx_data),
        .busy_o(busy),
        .done_o(done),
        .rx_word_o(rx_word),
        .sclk_o(sclk_int),
        .sdo_o(sdo_int)
    );

    // pins are re-registered so every output comes from a flop
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            SCLK_O <= 1'b0;
            SCLK_OE_O <= 1'b0;
            SDO_O <= 1'b0;
            SDO_OE_O <= 1'b0;
        end else begin
            SCLK_O <= sclk_int;
            SCLK_OE_O <= enable && master; // see RULE20
            SDO_O <= sdo_int;
            SDO_OE_O <= enable && (master || !CS_N_I); // see RULE1
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            CS_N_O <= 1'b1;
        end else if (!enable || !master) begin
            CS_N_O <= 1'b1; // see RULE14
        end else if (port_ctrl[SFF_PC_SELECT_CTRL]) begin
            CS_N_O <= !busy; // see RULE19
        end else begin
            CS_N_O <= select_output_reg[0]; // see RULE14
        end
    end
endmodule

// file: sim/sff_top_props.sv
// concurrent checks on the frame-format port bus and pin enables
`timescale 1ns/1ns
module sff_top_props (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HRESP_O,
    input wire logic SCLK_OE_O,
    input wire logic SDO_OE_O,
    input wire logic CS_N_I,
    input wire logic CS_N_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    logic go;
    logic ctl_wr;
    assign go = HSEL_I && HREADY_I && HTRANS_I[1];
    assign ctl_wr = go && HWRITE_I && HADDR_I == 8'h18;
    sequence rd_req;
        go && !HWRITE_I;
    endsequence
    a_resp_okay: assert property (HRESP_O == 1'b0)
        else $error("bus response is not okay");
    a_rdata_hold: assert property (!(go && !HWRITE_I) |=> $stable(HRDATA_O))
        else $error("read data moved without a read");
    a_hole_zero: assert property
        (rd_req ##0 (HADDR_I > 8'h2c) |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_format_upper: assert property
        (rd_req ##0 (HADDR_I == 8'h1c) |=> HRDATA_O[31:7] == 25'h0)
        else $error("format register upper bits set");
    // the clock drive enable may only appear as a result of a control write
    a_oe_cause: assert property
        ($rose(SCLK_OE_O) |-> $past(ctl_wr, 2) || $past(ctl_wr, 3)
            || $past(ctl_wr, 4))
        else $error("clock drive enabled without control write");
    a_master_drive: assert property (SCLK_OE_O |-> SDO_OE_O)
        else $error("master data pin not driven");
    a_slave_quiet: assert property
        (!SCLK_OE_O && $past(CS_N_I) |-> !SDO_OE_O)
        else $error("data pin driven while unselected");
    a_cs_idle: assert property
        (!SCLK_OE_O && !$past(SCLK_OE_O) |-> CS_N_O)
        else $error("select asserted outside master mode");
endmodule

bind sff_top sff_top_props props (.*);

// file: sim/sff_peer_model.sv
// far-side serial device: loops data back and records the wire
`timescale 1ns/1ns
module sff_peer_model (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic sdo_i,
    input wire logic cs_n_i,
    input wire logic phase_i,
    output logic sdi_o,
    output logic [6:0] edges_o,
    output logic [31:0] cap_o,
    output logic [7:0] gap_o
);
    logic sclk_d = 1'b0;
    logic flip = 1'b0;
    logic [7:0] run = 8'h00;
    // unselected line toggles so a stale level cannot pass as data
    assign sdi_o = cs_n_i ? flip : sdo_i;
    always @(posedge clk_i) begin
        flip <= ~flip;
        sclk_d <= sclk_i;
        run <= run + 8'h01;
        if (cs_n_i) begin
            edges_o <= 7'h00;
            cap_o <= 32'h0;
        end else if (sclk_i != sclk_d) begin
            edges_o <= edges_o + 7'h01;
            gap_o <= run;
            run <= 8'h01;
            if (edges_o[0] != phase_i)
                cap_o <= {cap_o[30:0], sdo_i};
        end
    end
endmodule

// file: sim/sff_top_test.sv
// self-checking bench for the frame-format port over AHB-Lite
`timescale 1ns/1ns
module sff_top_test;
    import sff_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic chk = 1'b0;
    logic dp = 1'b0;
    logic phase = 1'b0;
    logic hready, hresp, sclk, sclk_oe, sdo, sdo_oe, cs_n, sdi;
    logic [31:0] hrdata, cap;
    logic [6:0] edges;
    logic [7:0] gap;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int compares = 0;
    int seed = 32'h275e;

    sff_top DUT (.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .SCLK_I(1'b0), .SCLK_O(sclk), .SCLK_OE_O(sclk_oe), .SDI_I(sdi),
        .SDO_O(sdo), .SDO_OE_O(sdo_oe), .CS_N_I(1'b1), .CS_N_O(cs_n));
    sff_peer_model peer (.clk_i(clk), .sclk_i(sclk), .sdo_i(sdo),
        .cs_n_i(cs_n), .phase_i(phase), .sdi_o(sdi), .edges_o(edges),
        .cap_o(cap), .gap_o(gap));

    initial forever #50 clk = ~clk;

    task automatic check(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // read data stands in the data phase; compare against the oldest note
    always @(posedge clk) begin
        if (dp && hready)
            check(exp_q.pop_front(), hrdata);
        dp <= hsel && htrans[1] && !hwrite && hready && chk;
    end

    task automatic xfer(input logic [7:0] a, input logic w,
            input logic [31:0] d, output logic [31:0] r, input logic c);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        chk <= c;
        htrans <= SFF_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0, r, 1'b1);
    endtask

    task automatic frame(input logic [6:0] ff, input logic [11:0] pc,
            input logic [4:0] ext, input int len, input logic lsb,
            input logic ph);
        logic [31:0] m, e, tx, s;
        int k;
        tx = $random(seed);
        m = (len == 32) ? 32'hffff_ffff : (32'h1 << len) - 32'h1;
        e = 32'h0;
        for (k = 0; k < len; k++)
            e[lsb ? len - 1 - k : k] = tx[k];
        phase <= ph;
        wr(SFF_PORT_CTRL_OFS, 32'h0);
        wr(SFF_SELECT_OUTPUT_OFS, 32'h0000_00ff);
        wr(SFF_FRAME_FORMAT_OFS, {25'h0, ff});
        wr(SFF_WORD_LENGTH_OFS, {27'h0, ext});
        wr(SFF_BAUD_DIVISOR_OFS, 32'h0000_0006);
        wr(SFF_SELECT_OUTPUT_OFS, 32'h0000_00fe);
        wr(SFF_PORT_CTRL_OFS, {20'h0, pc});
        wr(SFF_TX_DATA_OFS, tx);
        repeat (4) @(posedge clk);
        k = 0;
        do begin
            xfer(SFF_STATUS_OFS, 1'b0, 32'h0, s, 1'b0);
            k++;
        end while (s[SFF_ST_BUSY] !== 1'b0 && k < 500);
        if (k >= 500) mismatches++;
        repeat (2) @(posedge clk);
        check(2 * len, {25'h0, edges});
        check(e, cap & m);
        check(32'h0000_0003, {24'h0, gap});
        check({31'h0, ff[1]}, {31'h0, sclk});
        rd(SFF_RX_DATA_OFS, tx & m);
    endtask

    initial begin
        logic [31:0] w;
        int i;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(SFF_FRAME_FORMAT_OFS, 32'h0000_0008);
        rd(SFF_BAUD_DIVISOR_OFS, 32'h0000_0002);
        rd(SFF_RECEIVE_COUNT_OFS, 32'h0000_0001);
        rd(SFF_SELECT_OUTPUT_OFS, 32'h0000_00ff);
        rd(SFF_WORD_LENGTH_OFS, 32'h0000_0008);
        rd(SFF_PORT_CTRL_OFS, 32'h0000_0004);
        rd(8'h30, 32'h0);
        for (i = 0; i < 4; i++) begin
            w = $random(seed) | 32'h0000_0003;
            wr(SFF_BAUD_DIVISOR_OFS, w);
            rd(SFF_BAUD_DIVISOR_OFS, w & 32'h0000_ffff);
            wr(SFF_RECEIVE_COUNT_OFS, w);
            rd(SFF_RECEIVE_COUNT_OFS, w & 32'h0000_ffff);
            wr(SFF_FRAME_FORMAT_OFS, w);
            rd(SFF_FRAME_FORMAT_OFS, w & 32'h0000_007f);
        end
        check(32'h0, {31'h0, sclk_oe});
        frame(7'h08, 12'h005, 5'h08, 8, 1'b0, 1'b0);
        frame(7'h06, 12'h005, 5'h08, 7, 1'b1, 1'b0);
        frame(7'h48, 12'h805, 5'h00, 32, 1'b0, 1'b1);
        frame(7'h1d, 12'h805, 5'h0d, 13, 1'b1, 1'b1);
        frame(7'h06, 12'h105, 5'h05, 16, 1'b0, 1'b1);
        frame(7'h02, 12'h305, 5'h05, 32, 1'b0, 1'b1);
        final_report();
    end

    // cut a hang short well beyond the longest expected run
    initial begin
        #(100 * 40000);
        mismatches++;
        final_report();
    end
endmodule
